// file: core/otfa_object_temp_filter_alert.sv
// Object temperature correction, filter, limit alert and AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module otfa_object_temp_filter_alert
	import otfa_pkg::*;
(
	input  wire logic                  clk_sys_in,
	input  wire logic                  resetn_in,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic                  s_axi_awvalid_in,
	output logic                       s_axi_awready_out,
	input  wire logic [31:0]           s_axi_wdata_in,
	input  wire logic [3:0]            s_axi_wstrb_in,
	input  wire logic                  s_axi_wvalid_in,
	output logic                       s_axi_wready_out,
	output logic [1:0]                 s_axi_bresp_out,
	output logic                       s_axi_bvalid_out,
	input  wire logic                  s_axi_bready_in,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic                  s_axi_arvalid_in,
	output logic                       s_axi_arready_out,
	output logic [31:0]                s_axi_rdata_out,
	output logic [1:0]                 s_axi_rresp_out,
	output logic                       s_axi_rvalid_out,
	input  wire logic                  s_axi_rready_in,
	input  wire logic                  sample_valid_in,
	input  wire logic [DATA_W-1:0]     sensor_voltage_in,
	input  wire logic [DATA_W-1:0]     die_temp_in,
	output logic [DATA_W-1:0]          corrected_sensor_voltage_out,
	output logic                       corr_valid_out,
	input  wire logic                  obj_valid_in,
	input  wire logic [DATA_W-1:0]     obj_temp_in,
	input  wire logic                  alert_resp_done_in,
	input  wire logic                  alert_arb_won_in,
	output logic                       alert_out,
	output logic                       alert_cause_out,
	output logic                       irq_out
);

	typedef struct packed {
		logic [CFG_W-1:0]      cfg;
		logic [DATA_W-1:0]     w_die;
		logic [DATA_W-1:0]     w_volt;
		logic [DATA_W-1:0]     hi_lim;
		logic [DATA_W-1:0]     lo_lim;
		logic                  hi_flag;
		logic                  lo_flag;
		logic                  ready_flag;
		logic                  ovf_flag;
		logic                  pin_pend;
		logic [IRQ_W-1:0]      irq_stat;
		logic [IRQ_W-1:0]      irq_mask;
		logic                  aw_full;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic                  w_full;
		logic [31:0]           wdata;
		logic [3:0]            wstrb;
		logic                  aw_rdy;
		logic                  w_rdy;
		logic                  ar_rdy;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic                  alert;
		logic                  cause;
		logic                  irq;
	} otfa_top_state_type;

	otfa_top_state_type st_r;
	otfa_top_state_type st_nxt;
	logic [DATA_W-1:0]  corr_v;
	logic               corr_sat;
	logic [DATA_W-1:0]  result;
	logic               conv_end;
	logic               wr_go;
	logic               rd_clr;
	logic               hi_set;
	logic               lo_set;
	logic               above;
	logic               below;
	logic [IRQ_W-1:0]   irq_ev;
	logic [IRQ_W-1:0]   irq_clr;
	logic [31:0]        rd_word;
	logic               rd_hit;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0])
			res[7:0] = data[7:0];
		if (strb[1])
			res[15:8] = data[15:8];
		return res;
	endfunction

	otfa_slope_corr #(
		.W    (DATA_W),
		.FRAC (WEIGHT_FRAC)
	) u_corr (
		.clk_sys_in      (clk_sys_in),
		.resetn_in       (resetn_in),
		.enable_in       (st_r.cfg[CFG_TC_EN]),
		.sample_valid_in (sample_valid_in),
		.v_in            (sensor_voltage_in),
		.t_in            (die_temp_in),
		.w_die_in        (st_r.w_die),
		.w_volt_in       (st_r.w_volt),
		.v_out           (corr_v),
		.valid_out       (corr_valid_out),
		.sat_out         (corr_sat)
	);

	otfa_out_filter #(
		.W (DATA_W)
	) u_filt (
		.clk_sys_in (clk_sys_in),
		.resetn_in  (resetn_in),
		.enable_in  (st_r.cfg[CFG_TC_EN]),
		.valid_in   (obj_valid_in),
		.x_in       (obj_temp_in),
		.y_out      (result),
		.valid_out  (conv_end)
	);

	assign corrected_sensor_voltage_out = corr_v;

	// Read data decode
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr_in)
			OFS_CONFIG:       rd_word[CFG_W-1:0] = st_r.cfg;
			OFS_DIE_WEIGHT:   rd_word[15:0] = st_r.w_die;
			OFS_VOLT_WEIGHT:  rd_word[15:0] = st_r.w_volt;
			OFS_HIGH_LIMIT:   rd_word[15:0] = st_r.hi_lim;
			OFS_LOW_LIMIT:    rd_word[15:0] = st_r.lo_lim;
			OFS_LIMIT_STATUS:
			begin
				rd_word[STS_HI] = st_r.hi_flag;
				rd_word[STS_LO] = st_r.lo_flag;
				rd_word[STS_READY] = st_r.ready_flag;
				rd_word[STS_OVF] = st_r.ovf_flag;
			end
			OFS_OBJ_RESULT:   rd_word[15:0] = result;
			OFS_CORR_VOLT:    rd_word[15:0] = corr_v;
			OFS_IRQ_STATUS:   rd_word[IRQ_W-1:0] = st_r.irq_stat;
			OFS_IRQ_MASK:     rd_word[IRQ_W-1:0] = st_r.irq_mask;
			default:          rd_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		st_nxt = st_r;
		irq_clr = '0;
		wr_go = st_r.aw_full && st_r.w_full && !st_r.bvalid;
		rd_clr = 1'b0;

		// Write address and data are taken independently
		if (s_axi_awvalid_in && st_r.aw_rdy)
		begin
			st_nxt.aw_full = 1'b1;
			st_nxt.awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && st_r.w_rdy)
		begin
			st_nxt.w_full = 1'b1;
			st_nxt.wdata = s_axi_wdata_in;
			st_nxt.wstrb = s_axi_wstrb_in;
		end
		if (st_r.bvalid && s_axi_bready_in)
			st_nxt.bvalid = 1'b0;
		if (wr_go)
		begin
			st_nxt.aw_full = 1'b0;
			st_nxt.w_full = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			case (st_r.awaddr)
				OFS_CONFIG:
					if (st_r.wstrb[0])
						st_nxt.cfg = st_r.wdata[CFG_W-1:0];
				OFS_DIE_WEIGHT:   st_nxt.w_die = merge16(st_r.w_die, st_r.wdata, st_r.wstrb);
				OFS_VOLT_WEIGHT:  st_nxt.w_volt = merge16(st_r.w_volt, st_r.wdata, st_r.wstrb);
				OFS_HIGH_LIMIT:   st_nxt.hi_lim = merge16(st_r.hi_lim, st_r.wdata, st_r.wstrb);
				OFS_LOW_LIMIT:    st_nxt.lo_lim = merge16(st_r.lo_lim, st_r.wdata, st_r.wstrb);
				OFS_IRQ_STATUS:
					if (st_r.wstrb[0])
						irq_clr = st_r.wdata[IRQ_W-1:0];
				OFS_IRQ_MASK:
					if (st_r.wstrb[0])
						st_nxt.irq_mask = st_r.wdata[IRQ_W-1:0];
				default:          st_nxt.bresp = RESP_SLVERR;
			endcase
		end
		st_nxt.aw_rdy = !st_nxt.aw_full;
		st_nxt.w_rdy = !st_nxt.w_full;

		// Read channel, one outstanding
		if (st_r.rvalid && s_axi_rready_in)
			st_nxt.rvalid = 1'b0;
		if (s_axi_arvalid_in && st_r.ar_rdy)
		begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rd_word;
			st_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
			rd_clr = (s_axi_araddr_in == OFS_LIMIT_STATUS);
		end
		st_nxt.ar_rdy = !st_nxt.rvalid;

		// Limit compare on the final result
		above = $signed(result) > $signed(st_r.hi_lim);
		below = $signed(result) < $signed(st_r.lo_lim);
		hi_set = 1'b0;
		lo_set = 1'b0;
		if (!st_r.cfg[CFG_MODE])
		begin
			hi_set = conv_end && st_r.cfg[CFG_HI_EN] && above;
			lo_set = conv_end && st_r.cfg[CFG_LO_EN] && below;
			// Set wins over a status read in the same cycle
			st_nxt.hi_flag = (st_r.hi_flag && !rd_clr) || hi_set;
			st_nxt.lo_flag = (st_r.lo_flag && !rd_clr) || lo_set;
			if (rd_clr)
				st_nxt.pin_pend = 1'b0;
			if (alert_resp_done_in && alert_arb_won_in && st_r.alert)
				st_nxt.pin_pend = 1'b0;
			if (hi_set || lo_set)
				st_nxt.pin_pend = 1'b1;
		end
		else
		begin
			st_nxt.lo_flag = 1'b0;
			st_nxt.pin_pend = 1'b0;
			if (conv_end)
			begin
				if (!st_r.cfg[CFG_HI_EN])
					st_nxt.hi_flag = 1'b0;
				else if (above)
				begin
					st_nxt.hi_flag = 1'b1;
					hi_set = !st_r.hi_flag;
				end
				else if (below)
					st_nxt.hi_flag = 1'b0;
			end
		end
		st_nxt.alert = st_r.cfg[CFG_PIN_EN] && (st_r.cfg[CFG_MODE] ? st_nxt.hi_flag : st_nxt.pin_pend);
		st_nxt.cause = st_nxt.hi_flag;

		// Status extras, set wins over read clear
		st_nxt.ready_flag = (st_r.ready_flag && !rd_clr) || conv_end;
		st_nxt.ovf_flag = (st_r.ovf_flag && !rd_clr) || (corr_valid_out && corr_sat);

		// Sticky interrupt events, write one to clear, set wins
		irq_ev = '0;
		irq_ev[IRQ_CONV] = conv_end;
		irq_ev[IRQ_HIGH] = hi_set;
		irq_ev[IRQ_LOW] = lo_set;
		irq_ev[IRQ_OVF] = corr_valid_out && corr_sat;
		st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_ev;
		st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);

		if (!resetn_in)
		begin
			st_nxt = '0;
			st_nxt.cfg = CONFIG_RST;
			st_nxt.w_die = DIE_WEIGHT_RST;
			st_nxt.w_volt = VOLT_WEIGHT_RST;
			st_nxt.hi_lim = HIGH_LIMIT_RST;
			st_nxt.lo_lim = LOW_LIMIT_RST;
			st_nxt.irq_mask = IRQ_MASK_RST;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		st_r <= st_nxt;
	end

	assign s_axi_awready_out = st_r.aw_rdy;
	assign s_axi_wready_out = st_r.w_rdy;
	assign s_axi_bresp_out = st_r.bresp;
	assign s_axi_bvalid_out = st_r.bvalid;
	assign s_axi_arready_out = st_r.ar_rdy;
	assign s_axi_rdata_out = st_r.rdata;
	assign s_axi_rresp_out = st_r.rresp;
	assign s_axi_rvalid_out = st_r.rvalid;
	assign alert_out = st_r.alert;
	assign alert_cause_out = st_r.cause;
	assign irq_out = st_r.irq;

endmodule
`default_nettype wire

// file: core/otfa_pkg.sv
// Constants shared by the object temperature filter and alert block
package otfa_pkg;

	localparam int DATA_W       = 16;
	localparam int AXI_ADDR_W   = 8;
	localparam int WEIGHT_FRAC  = 8;
	localparam int FILT_NEW_NUM = 1;
	localparam int FILT_OLD_NUM = 4;
	localparam int FILT_DEN     = 5;

	localparam logic [7:0] OFS_CONFIG       = 8'h00;
	localparam logic [7:0] OFS_DIE_WEIGHT   = 8'h04;
	localparam logic [7:0] OFS_VOLT_WEIGHT  = 8'h08;
	localparam logic [7:0] OFS_HIGH_LIMIT   = 8'h0C;
	localparam logic [7:0] OFS_LOW_LIMIT    = 8'h10;
	localparam logic [7:0] OFS_LIMIT_STATUS = 8'h14;
	localparam logic [7:0] OFS_OBJ_RESULT   = 8'h18;
	localparam logic [7:0] OFS_CORR_VOLT    = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STATUS   = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK     = 8'h24;

	localparam int CFG_TC_EN    = 0;
	localparam int CFG_MODE     = 1;
	localparam int CFG_PIN_EN   = 2;
	localparam int CFG_HI_EN    = 3;
	localparam int CFG_LO_EN    = 4;
	localparam int CFG_W        = 5;

	localparam int STS_HI       = 0;
	localparam int STS_LO       = 1;
	localparam int STS_READY    = 2;
	localparam int STS_OVF      = 3;

	localparam int IRQ_CONV     = 0;
	localparam int IRQ_HIGH     = 1;
	localparam int IRQ_LOW      = 2;
	localparam int IRQ_OVF      = 3;
	localparam int IRQ_W        = 4;

	localparam logic [CFG_W-1:0]  CONFIG_RST     = 5'h00;
	localparam logic [15:0]       DIE_WEIGHT_RST = 16'h0000;
	localparam logic [15:0]       VOLT_WEIGHT_RST = 16'h0000;
	localparam logic [15:0]       HIGH_LIMIT_RST = 16'h7FC0;
	localparam logic [15:0]       LOW_LIMIT_RST  = 16'h8000;
	localparam logic [IRQ_W-1:0]  IRQ_MASK_RST   = 4'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: core/otfa_slope_corr.sv
// Transient correction of the sensor voltage from die and voltage slopes
`timescale 1ns/10ps
`default_nettype none
module otfa_slope_corr
	import otfa_pkg::*;
#(
	parameter int W    = DATA_W,
	parameter int FRAC = WEIGHT_FRAC
)
(
	input  wire logic         clk_sys_in,
	input  wire logic         resetn_in,
	input  wire logic         enable_in,
	input  wire logic         sample_valid_in,
	input  wire logic [W-1:0] v_in,
	input  wire logic [W-1:0] t_in,
	input  wire logic [W-1:0] w_die_in,
	input  wire logic [W-1:0] w_volt_in,
	output logic      [W-1:0] v_out,
	output logic              valid_out,
	output logic              sat_out
);

	localparam int ACC_W = 2 * W + 2;
	localparam logic signed [ACC_W-1:0] VMAX = ACC_W'((2 ** (W - 1)) - 1);
	localparam logic signed [ACC_W-1:0] VMIN = -VMAX - ACC_W'(1);

	typedef struct packed {
		logic         have_prev;
		logic [W-1:0] v_prev;
		logic [W-1:0] t_prev;
		logic [W-1:0] v_out;
		logic         valid;
		logic         sat;
	} otfa_corr_state_type;

	otfa_corr_state_type st_r;
	otfa_corr_state_type st_nxt;
	logic signed [ACC_W-1:0] d_t;
	logic signed [ACC_W-1:0] d_v;
	logic signed [ACC_W-1:0] acc;
	logic signed [ACC_W-1:0] total;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.valid = 1'b0;
		d_t = '0;
		d_v = '0;
		if (st_r.have_prev)
		begin
			d_t = ACC_W'($signed(t_in)) - ACC_W'($signed(st_r.t_prev));
			d_v = ACC_W'($signed(v_in)) - ACC_W'($signed(st_r.v_prev));
		end
		// Zero weights leave the voltage untouched
		acc = (ACC_W'($signed(w_die_in)) * d_t + ACC_W'($signed(w_volt_in)) * d_v) >>> FRAC;
		total = ACC_W'($signed(v_in)) + acc;
		if (sample_valid_in)
		begin
			st_nxt.have_prev = 1'b1;
			st_nxt.v_prev = v_in;
			st_nxt.t_prev = t_in;
			st_nxt.valid = 1'b1;
			st_nxt.sat = 1'b0;
			if (!enable_in)
				st_nxt.v_out = v_in;
			else if (total > VMAX)
			begin
				st_nxt.v_out = W'(VMAX);
				st_nxt.sat = 1'b1;
			end
			else if (total < VMIN)
			begin
				st_nxt.v_out = W'(VMIN);
				st_nxt.sat = 1'b1;
			end
			else
				st_nxt.v_out = W'(total);
		end
		if (!resetn_in)
			st_nxt = '0;
	end

	always_ff @(posedge clk_sys_in)
	begin
		st_r <= st_nxt;
	end

	assign v_out = st_r.v_out;
	assign valid_out = st_r.valid;
	assign sat_out = st_r.sat;

endmodule
`default_nettype wire

// file: core/otfa_out_filter.sv
// First-order output filter of the object temperature result
`timescale 1ns/10ps
`default_nettype none
module otfa_out_filter
	import otfa_pkg::*;
#(
	parameter int W = DATA_W
)
(
	input  wire logic         clk_sys_in,
	input  wire logic         resetn_in,
	input  wire logic         enable_in,
	input  wire logic         valid_in,
	input  wire logic [W-1:0] x_in,
	output logic      [W-1:0] y_out,
	output logic              valid_out
);

	localparam int SUM_W = W + 4;
	localparam logic signed [SUM_W-1:0] K_NEW = SUM_W'(FILT_NEW_NUM);
	localparam logic signed [SUM_W-1:0] K_OLD = SUM_W'(FILT_OLD_NUM);
	localparam logic signed [SUM_W-1:0] K_DEN = SUM_W'(FILT_DEN);

	typedef struct packed {
		logic         primed;
		logic [W-1:0] y;
		logic         valid;
	} otfa_filt_state_type;

	otfa_filt_state_type st_r;
	otfa_filt_state_type st_nxt;
	logic signed [SUM_W-1:0] sum;
	logic signed [SUM_W-1:0] quo;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.valid = 1'b0;
		sum = K_NEW * SUM_W'($signed(x_in)) + K_OLD * SUM_W'($signed(st_r.y));
		quo = sum / K_DEN;
		if (!enable_in)
			st_nxt.primed = 1'b0;
		if (valid_in)
		begin
			st_nxt.valid = 1'b1;
			if (!enable_in)
				st_nxt.y = x_in;
			else if (!st_r.primed)
			begin
				st_nxt.y = x_in;
				st_nxt.primed = 1'b1;
			end
			else
				st_nxt.y = W'(quo);
		end
		if (!resetn_in)
			st_nxt = '0;
	end

	always_ff @(posedge clk_sys_in)
	begin
		st_r <= st_nxt;
	end

	assign y_out = st_r.y;
	assign valid_out = st_r.valid;

endmodule
`default_nettype wire

// file: bench/otfa_alert_host.sv
// Host model answering the alert with a response after a delay
`timescale 1ns/10ps
`default_nettype none
module otfa_alert_host
(
	input  wire logic       clk_sys_in,
	input  wire logic       resetn_in,
	input  wire logic       alert_in,
	input  wire logic       start_in,
	input  wire logic       win_in,
	input  wire logic [3:0] delay_in,
	output logic            done_out,
	output logic            won_out
);
	logic       busy_r;
	logic [3:0] cnt_r;
	always @(posedge clk_sys_in)
	begin
		done_out <= 1'b0;
		if (!resetn_in)
		begin
			busy_r <= 1'b0;
			won_out <= 1'b0;
		end
		else if (busy_r && cnt_r == 4'h0)
		begin
			done_out <= 1'b1;
			won_out <= win_in;
			busy_r <= 1'b0;
		end
		else if (busy_r)
			cnt_r <= cnt_r - 4'h1;
		else if (start_in && alert_in)
		begin
			busy_r <= 1'b1;
			cnt_r <= delay_in;
		end
	end
endmodule
`default_nettype wire

// file: bench/otfa_object_temp_filter_alert_assertions.sv
// Checker for bus and data path timing at the block ports
`timescale 1ns/10ps
`default_nettype none
module otfa_checker
(
	input wire logic        clk_sys_in,
	input wire logic        resetn_in,
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic        sample_valid_in,
	input wire logic        corr_valid_out,
	input wire logic        obj_valid_in,
	input wire logic        alert_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	sequence s_wr_take;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out && !s_axi_bvalid_out;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence
	property p_wr_answer; s_wr_take |-> ##2 s_axi_bvalid_out; endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	property p_aw_busy; s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out; endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("awready stayed high");
	property p_b_done; s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out; endproperty
	a_b_done: assert property (p_b_done) else $error("bvalid stayed high");
	property p_rd_answer; s_rd_take |=> s_axi_rvalid_out && !s_axi_arready_out; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_rd_hold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
	property p_rd_done; s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out; endproperty
	a_rd_done: assert property (p_rd_done) else $error("rvalid stayed high");
	property p_corr_pulse; sample_valid_in |=> corr_valid_out; endproperty
	a_corr_pulse: assert property (p_corr_pulse) else $error("no corrected sample");
	property p_corr_quiet; !sample_valid_in |=> !corr_valid_out; endproperty
	a_corr_quiet: assert property (p_corr_quiet) else $error("stray corrected sample");
	property p_alert_rise; $rose(alert_out) |-> $past(obj_valid_in, 2); endproperty
	a_alert_rise: assert property (p_alert_rise) else $error("alert rose off conversion");
endmodule
`default_nettype wire

// file: bench/otfa_object_temp_filter_alert_tb.sv
// Self-checking bench of the object temperature filter and alert block
`timescale 1ns/10ps
`default_nettype none
module otfa_object_temp_filter_alert_tb
	import otfa_pkg::*;
;
	logic                  clk_sys_in = 1'b0;
	logic                  resetn_in, resp_start, resp_win;
	logic [AXI_ADDR_W-1:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0]           s_axi_wdata_in, s_axi_rdata_out, rs, rd_d;
	logic [3:0]            s_axi_wstrb_in, resp_delay;
	logic [1:0]            s_axi_bresp_out, s_axi_rresp_out, rd_r;
	logic                  s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
	logic                  s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
	logic                  s_axi_rvalid_out, s_axi_rready_in, sample_valid_in, corr_valid_out, obj_valid_in;
	logic [DATA_W-1:0]     sensor_voltage_in, die_temp_in, corrected_sensor_voltage_out, obj_temp_in;
	logic                  alert_resp_done_in, alert_arb_won_in, alert_out, alert_cause_out, irq_out;
	logic signed [15:0]    pv, pt, v, t, x, y, wd, wv;
	int                    fails, n_compared;
	always #2.5 clk_sys_in = ~clk_sys_in;
	otfa_object_temp_filter_alert dut
	(
		.clk_sys_in, .resetn_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
		.s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
		.s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
		.s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .sample_valid_in, .sensor_voltage_in,
		.die_temp_in, .corrected_sensor_voltage_out, .corr_valid_out, .obj_valid_in, .obj_temp_in,
		.alert_resp_done_in, .alert_arb_won_in, .alert_out, .alert_cause_out, .irq_out
	);
	otfa_alert_host host
	(
		.clk_sys_in, .resetn_in, .alert_in(alert_out), .start_in(resp_start), .win_in(resp_win),
		.delay_in(resp_delay), .done_out(alert_resp_done_in), .won_out(alert_arb_won_in)
	);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] corr_f(input logic signed [15:0] vv, dv, dt, a, b);
		logic signed [40:0] s;
		s = vv + ((a * dt + b * dv) >>> WEIGHT_FRAC);
		if (s > 32767)
			return 16'h7FFF;
		if (s < -32768)
			return 16'h8000;
		return s[15:0];
	endfunction
	function automatic logic signed [15:0] filt(input logic signed [15:0] xx, yy);
		logic signed [19:0] s;
		s = xx;
		s = (s * FILT_NEW_NUM + FILT_OLD_NUM * yy) / FILT_DEN;
		return s[15:0];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] e);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		for (int k = 0; k < 40; k++)
		begin
			@(posedge clk_sys_in);
			if (s_axi_awvalid_in && s_axi_awready_out)
				s_axi_awvalid_in <= 1'b0;
			if (s_axi_wvalid_in && s_axi_wready_out)
				s_axi_wvalid_in <= 1'b0;
			if (s_axi_bvalid_out === 1'b1)
				break;
		end
		s_axi_bready_in <= 1'b0;
		chk({s_axi_bvalid_out, s_axi_bresp_out}, {1'b1, e});
		@(posedge clk_sys_in);
	endtask
	task automatic rd(input logic [AXI_ADDR_W-1:0] a);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		for (int k = 0; k < 40; k++)
		begin
			@(posedge clk_sys_in);
			if (s_axi_arvalid_in && s_axi_arready_out)
				s_axi_arvalid_in <= 1'b0;
			if (s_axi_rvalid_out === 1'b1 && s_axi_rready_in)
				break;
			if (s_axi_rvalid_out === 1'b1)
				s_axi_rready_in <= 1'b1;
		end
		s_axi_rready_in <= 1'b0;
		chk(s_axi_rvalid_out, 1'b1);
		rd_d = s_axi_rdata_out;
		rd_r = s_axi_rresp_out;
		@(posedge clk_sys_in);
	endtask
	task automatic rc(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] e);
		rd(a);
		chk(rd_r, RESP_OKAY);
		chk(rd_d, e);
	endtask
	task automatic samp(input logic [15:0] e);
		sample_valid_in <= 1'b1;
		@(posedge clk_sys_in);
		sample_valid_in <= 1'b0;
		@(posedge clk_sys_in);
		chk(corrected_sensor_voltage_out, e);
	endtask
	task automatic obj(input logic [15:0] d);
		obj_temp_in <= d;
		obj_valid_in <= 1'b1;
		@(posedge clk_sys_in);
		obj_valid_in <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
	endtask
	task automatic resp(input logic w);
		resp_start <= 1'b1;
		resp_win <= w;
		resp_delay <= rs[3:0];
		@(posedge clk_sys_in);
		resp_start <= 1'b0;
		for (int k = 0; k < 30 && alert_resp_done_in !== 1'b1; k++)
			@(posedge clk_sys_in);
		chk(alert_resp_done_in, 1'b1);
		repeat (3) @(posedge clk_sys_in);
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		{resetn_in, resp_start, resp_win, resp_delay, s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
		{sample_valid_in, sensor_voltage_in, die_temp_in, obj_valid_in, obj_temp_in} = '0;
		s_axi_wstrb_in = 4'hF;
		rs = 32'h4362E72F;
		repeat (6) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		rc(OFS_CONFIG, 32'h0);
		rc(OFS_HIGH_LIMIT, 32'h7FC0);
		rc(OFS_LOW_LIMIT, 32'h8000);
		rc(OFS_IRQ_MASK, 32'h0);
		rd(8'h30);
		chk(rd_r, RESP_SLVERR);
		wr(OFS_OBJ_RESULT, 32'h1234, RESP_SLVERR);
		sensor_voltage_in <= rs[15:0];
		die_temp_in <= rs[31:16];
		samp(rs[15:0]);
		obj(rs[31:16]);
		rc(OFS_OBJ_RESULT, {16'h0, rs[31:16]});
		$display("test registers and raw path done");
		wr(OFS_CONFIG, 32'h1, RESP_OKAY);
		{pv, pt, wd, wv} = '0;
		for (int i = 0; i < 10; i++)
		begin
			if (i == 5)
			begin
				wd = {{8{rs[7]}}, rs[7:0]};
				wv = {{8{rs[15]}}, rs[15:8]};
				wr(OFS_DIE_WEIGHT, {16'h0, wd}, RESP_OKAY);
				wr(OFS_VOLT_WEIGHT, {16'h0, wv}, RESP_OKAY);
			end
			rs = lfsr(rs);
			v = {{2{rs[13]}}, rs[13:0]};
			t = {{2{rs[29]}}, rs[29:16]};
			sensor_voltage_in <= v;
			die_temp_in <= t;
			samp(corr_f(v, v - pv, t - pt, wd, wv));
			pv = v;
			pt = t;
			rs = lfsr(rs);
			x = rs[15:0];
			y = (i == 0) ? x : filt(x, y);
			obj(x);
			rc(OFS_OBJ_RESULT, {16'h0, y});
		end
		wr(OFS_VOLT_WEIGHT, 32'h7FFF, RESP_OKAY);
		sensor_voltage_in <= 16'h7FFF;
		samp(16'h7FFF);
		$display("test correction and filter done");
		wr(OFS_CONFIG, 32'h1C, RESP_OKAY);
		wr(OFS_HIGH_LIMIT, 32'h0064, RESP_OKAY);
		wr(OFS_LOW_LIMIT, 32'hFF9C, RESP_OKAY);
		rc(OFS_LIMIT_STATUS, 32'hC);
		obj(16'h00C8);
		chk(alert_cause_out, 1'b1);
		resp(1'b0);
		chk(alert_out, 1'b1);
		resp(1'b1);
		chk(alert_out, 1'b0);
		rc(OFS_LIMIT_STATUS, 32'h5);
		rc(OFS_LIMIT_STATUS, 32'h0);
		obj(16'hFF38);
		chk({alert_out, alert_cause_out}, 2'b10);
		rc(OFS_LIMIT_STATUS, 32'h6);
		chk(alert_out, 1'b0);
		wr(OFS_CONFIG, 32'h18, RESP_OKAY);
		obj(16'h00C8);
		chk(alert_out, 1'b0);
		rc(OFS_LIMIT_STATUS, 32'h5);
		$display("test latched alert done");
		wr(OFS_CONFIG, 32'h1E, RESP_OKAY);
		obj(16'h00C8);
		chk(alert_out, 1'b1);
		rc(OFS_LIMIT_STATUS, 32'h5);
		rc(OFS_LIMIT_STATUS, 32'h1);
		resp(1'b1);
		chk(alert_out, 1'b1);
		obj(16'h0000);
		chk(alert_out, 1'b1);
		obj(16'hFF38);
		chk(alert_out, 1'b0);
		rc(OFS_LIMIT_STATUS, 32'h4);
		$display("test hysteresis alert done");
		rc(OFS_IRQ_STATUS, 32'hF);
		wr(OFS_IRQ_STATUS, 32'hF, RESP_OKAY);
		wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
		chk(irq_out, 1'b0);
		obj(16'h0000);
		chk(irq_out, 1'b1);
		wr(OFS_IRQ_STATUS, 32'h1, RESP_OKAY);
		chk(irq_out, 1'b0);
		wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
		obj(16'h0000);
		chk(irq_out, 1'b0);
		$display("test interrupt done");
		resetn_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		rc(OFS_LOW_LIMIT, 32'h8000);
		rc(OFS_IRQ_STATUS, 32'h0);
		$display("test reset done");
		conclude();
	end
	initial
	begin
		repeat (20000) @(posedge clk_sys_in);
		fails++;
		conclude();
	end
endmodule
bind otfa_object_temp_filter_alert otfa_checker chk_i
(
	.clk_sys_in, .resetn_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
	.s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
	.s_axi_rready_in, .s_axi_rdata_out, .sample_valid_in, .corr_valid_out, .obj_valid_in, .alert_out
);
`default_nettype wire
